// *** pkg/fcr_regs.vh ***
// Register addresses, field positions, reset values and timing constants of the flash control registers.
`ifndef FCR_REGS_VH
`define FCR_REGS_VH
`define FCR_ADDR_TORCH 8'ha0
`define FCR_ADDR_FLASH 8'hb0
`define FCR_ADDR_DUR 8'hc0
`define FCR_RST_TORCH 8'h50
`define FCR_RST_FLASH 8'h68
`define FCR_RST_DUR 8'h4f
`define FCR_RST_FCUR 4'hd
`define FCR_RST_LIM 2'h2
`define FCR_MODE_HI 2
`define FCR_MODE_LO 0
`define FCR_FCUR_HI 6
`define FCR_FCUR_LO 3
`define FCR_TRIG_BIT 7
`define FCR_TOUT_HI 4
`define FCR_TOUT_LO 0
`define FCR_LIM_HI 6
`define FCR_LIM_LO 5
`define FCR_DUR_WMASK 8'h7f
`define FCR_MODE_SHUT 3'h0
`define FCR_MODE_IND 3'h1
`define FCR_MODE_TORCH 3'h2
`define FCR_MODE_FLASH 3'h3
`define FCR_MODE_VOUT 3'h4
`define FCR_MODE_VIND 3'h5
`define FCR_MODE_VTORCH 3'h6
`define FCR_MODE_VFLASH 3'h7
`define FCR_STEP_MS 32
`define FCR_CLK_KHZ 200000
`define FCR_STEP_CYC (`FCR_STEP_MS * `FCR_CLK_KHZ)
`endif

// *** design/fcr_step_timer.v ***
// Flash timeout counter counting whole timeout steps.
`timescale 1ns/100ps
module fcr_step_timer #(
  parameter STEP_CYC = 6400000,
  parameter CW = 23
)
(
  clk,
  resetn,
  start,
  stop,
  code,
  running,
  expired
);
  input wire clk;
  input wire resetn;
  input wire start;
  input wire stop;
  input wire [4:0] code;
  output reg running;
  output reg expired;
  reg [CW-1:0] cyc_r;
  reg [4:0] steps_r;
  localparam [31:0] LAST_W = STEP_CYC - 1;
  localparam [CW-1:0] LAST = LAST_W[CW-1:0];
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cyc_r <= {CW{1'b0}};
      steps_r <= 5'h00;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (start)
      begin
        // The code is captured now; later writes do not stretch this flash.
        // The start cycle counts as the first of the step, so STEP_CYC must be at least two.
        cyc_r <= {{(CW-1){1'b0}}, 1'b1};
        steps_r <= code;
        running <= 1'b1;
      end
      else if (stop)
      begin
        running <= 1'b0;
      end
      else if (running)
      begin
        if (cyc_r == LAST)
        begin
          cyc_r <= {CW{1'b0}};
          if (steps_r == 5'h00)
          begin
            running <= 1'b0;
            expired <= 1'b1;
          end
          else
          begin
            steps_r <= steps_r - 5'h01;
          end
        end
        else
        begin
          cyc_r <= cyc_r + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // fcr_step_timer

// *** design/fcr_flash_ctrl.v ***
// Flash brightness and flash duration registers with trigger and timeout control.
`timescale 1ns/100ps
`include "fcr_regs.vh"
module fcr_flash_ctrl #(
  parameter STEP_CYC = `FCR_STEP_CYC
)
(
  clk,
  resetn,
  reg_wr,
  reg_rd,
  reg_addr,
  reg_wdata,
  reg_rdata,
  trigger_in,
  torch_level_and_mode,
  flash_level_and_mode,
  flash_timing_and_limit,
  mode_shutdown,
  mode_indicator,
  mode_torch,
  mode_flash,
  voltage_output_select,
  flash_current_code,
  peak_limit_code,
  flash_on,
  flash_timed_out
);
  input wire clk;
  input wire resetn;
  input wire reg_wr;
  input wire reg_rd;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  output reg [7:0] reg_rdata;
  input wire trigger_in;
  output reg [7:0] torch_level_and_mode;
  output reg [7:0] flash_level_and_mode;
  output reg [7:0] flash_timing_and_limit;
  output reg mode_shutdown;
  output reg mode_indicator;
  output reg mode_torch;
  output reg mode_flash;
  output reg voltage_output_select;
  output reg [3:0] flash_current_code;
  output reg [1:0] peak_limit_code;
  output reg flash_on;
  output reg flash_timed_out;

  localparam ST_IDLE = 3'b001;
  localparam ST_FLASH = 3'b010;
  localparam ST_WAITLOW = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg trig_d_r;
  wire trig_rise;
  wire [2:0] mode;
  wire flash_sel;
  wire edge_mode;
  wire tm_running;
  wire tm_expired;
  reg tm_start;
  reg tm_stop;

  assign mode = flash_level_and_mode[`FCR_MODE_HI:`FCR_MODE_LO];
  assign flash_sel = (mode == `FCR_MODE_FLASH) || (mode == `FCR_MODE_VFLASH);
  assign edge_mode = flash_level_and_mode[`FCR_TRIG_BIT];
  assign trig_rise = trigger_in & ~trig_d_r;

  fcr_step_timer #(
    .STEP_CYC(STEP_CYC),
    .CW(23)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .start(tm_start),
    .stop(tm_stop),
    .code(flash_timing_and_limit[`FCR_TOUT_HI:`FCR_TOUT_LO]),
    .running(tm_running),
    .expired(tm_expired)
  );

  always @*
  begin
    state_nxt = state_r;
    tm_start = 1'b0;
    tm_stop = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (flash_sel && trig_rise)
        begin
          state_nxt = ST_FLASH;
          tm_start = 1'b1;
        end
      end
      ST_FLASH:
      begin
        if (tm_expired)
        begin
          state_nxt = ST_IDLE;
        end
        else if (!flash_sel)
        begin
          state_nxt = ST_IDLE;
          tm_stop = 1'b1;
        end
        else if (!edge_mode && !trigger_in)
        begin
          // Level mode ends early on a low trigger.
          state_nxt = ST_IDLE;
          tm_stop = 1'b1;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      trig_d_r <= 1'b0;
      torch_level_and_mode <= `FCR_RST_TORCH;
      flash_level_and_mode <= `FCR_RST_FLASH;
      flash_timing_and_limit <= `FCR_RST_DUR;
      reg_rdata <= 8'h00;
      flash_on <= 1'b0;
      flash_timed_out <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      trig_d_r <= trigger_in;
      flash_timed_out <= tm_expired;
      // A torch or flash register write in the same cycle as a timeout wins over the clear, so the host's value is kept.
      if (reg_wr && reg_addr == `FCR_ADDR_FLASH)
      begin
        flash_level_and_mode <= reg_wdata;
        torch_level_and_mode[`FCR_MODE_HI:`FCR_MODE_LO] <= reg_wdata[`FCR_MODE_HI:`FCR_MODE_LO];
      end
      else if (reg_wr && reg_addr == `FCR_ADDR_TORCH)
      begin
        torch_level_and_mode <= reg_wdata;
        flash_level_and_mode[`FCR_MODE_HI:`FCR_MODE_LO] <= reg_wdata[`FCR_MODE_HI:`FCR_MODE_LO];
      end
      else if (tm_expired && state_r == ST_FLASH)
      begin
        // Only the low two bits select flash, so the voltage-output bit survives.
        flash_level_and_mode[1:0] <= 2'b00;
        torch_level_and_mode[1:0] <= 2'b00;
      end
      if (reg_wr && reg_addr == `FCR_ADDR_DUR)
      begin
        flash_timing_and_limit <= reg_wdata & `FCR_DUR_WMASK;
      end
      if (reg_rd)
      begin
        case (reg_addr)
          `FCR_ADDR_TORCH:
          begin
            reg_rdata <= torch_level_and_mode;
          end
          `FCR_ADDR_FLASH:
          begin
            reg_rdata <= flash_level_and_mode;
          end
          `FCR_ADDR_DUR:
          begin
            reg_rdata <= flash_timing_and_limit & `FCR_DUR_WMASK;
          end
          default:
          begin
            reg_rdata <= 8'h00;
          end
        endcase
      end
      // The start cycle itself counts, so the current stands exactly one timeout long.
      flash_on <= (state_nxt == ST_FLASH) && (tm_running || tm_start);
    end
  end

  // Decoded outputs follow the registers one cycle late and reset to what the reset values decode to.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_shutdown <= 1'b1;
      mode_indicator <= 1'b0;
      mode_torch <= 1'b0;
      mode_flash <= 1'b0;
      voltage_output_select <= 1'b0;
      flash_current_code <= `FCR_RST_FCUR;
      peak_limit_code <= `FCR_RST_LIM;
    end
    else
    begin
      mode_shutdown <= (mode == `FCR_MODE_SHUT);
      mode_indicator <= (mode == `FCR_MODE_IND) || (mode == `FCR_MODE_VIND);
      mode_torch <= (mode == `FCR_MODE_TORCH) || (mode == `FCR_MODE_VTORCH);
      mode_flash <= flash_sel;
      voltage_output_select <= mode[2];
      flash_current_code <= flash_level_and_mode[`FCR_FCUR_HI:`FCR_FCUR_LO];
      peak_limit_code <= flash_timing_and_limit[`FCR_LIM_HI:`FCR_LIM_LO];
    end
  end
endmodule // fcr_flash_ctrl

// *** tb/fcr_chk.sv ***
// Checker for the flash control registers.
`timescale 1ns/100ps
module fcr_chk (
  input wire clk,
  input wire resetn,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire trigger_in,
  input wire [7:0] torch_level_and_mode,
  input wire [7:0] flash_level_and_mode,
  input wire [7:0] flash_timing_and_limit,
  input wire mode_flash,
  input wire voltage_output_select,
  input wire [3:0] flash_current_code,
  input wire flash_on,
  input wire flash_timed_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_dec;
    mode_flash == ($past(flash_level_and_mode[1:0]) == 2'h3) && voltage_output_select == $past(flash_level_and_mode[2]);
  endproperty
  a_dec: assert property (p_dec) else $error("mode decode wrong");
  property p_cpf;
    reg_wr && reg_addr == 8'hb0 |=> torch_level_and_mode[2:0] == $past(reg_wdata[2:0]);
  endproperty
  a_cpf: assert property (p_cpf) else $error("flash mode not copied");
  property p_cpt;
    reg_wr && reg_addr == 8'ha0 |=> flash_level_and_mode[2:0] == $past(reg_wdata[2:0]);
  endproperty
  a_cpt: assert property (p_cpt) else $error("torch mode not copied");
  property p_cur;
    flash_current_code == $past(flash_level_and_mode[6:3]);
  endproperty
  a_cur: assert property (p_cur) else $error("current code wrong");
  property p_dur;
    reg_wr && reg_addr == 8'hc0 |=> flash_timing_and_limit == ($past(reg_wdata) & 8'h7f);
  endproperty
  a_dur: assert property (p_dur) else $error("duration write wrong");
  property p_go;
    $rose(trigger_in) && flash_level_and_mode[1:0] == 2'h3 && !flash_on |=> flash_on;
  endproperty
  a_go: assert property (p_go) else $error("flash did not start");
  property p_lvl;
    flash_on && !flash_level_and_mode[7] && !trigger_in |-> ##[1:2] !flash_on;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level flash did not stop");
  property p_clr;
    flash_timed_out && !$past(reg_wr) |-> flash_level_and_mode[1:0] == 2'h0 && !flash_on;
  endproperty
  a_clr: assert property (p_clr) else $error("timeout did not clear mode");
endmodule // fcr_chk

// *** tb/fcr_host.sv ***
// Host model: single-byte register writes and reads, driven on the falling edge.
`timescale 1ns/100ps
module fcr_host (
  input wire clk,
  input wire [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // Released data is inverted so a stale value is never mistaken for a live one.
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk) {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk) reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule // fcr_host

// *** tb/test_fcr_flash_ctrl.sv ***
// Self-checking testbench for the flash control registers.
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch t=%0t %h %h", $time, g, e); end end
module test_fcr_flash_ctrl;
  localparam STEP = 4;
  logic clk = 0, resetn = 0, trigger_in = 0, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, torch_level_and_mode, flash_level_and_mode, flash_timing_and_limit;
  logic mode_shutdown, mode_indicator, mode_torch, mode_flash, voltage_output_select, flash_on, flash_timed_out;
  logic [3:0] flash_current_code;
  logic [1:0] peak_limit_code;
  logic [7:0] t = 8'h50, f = 8'h68, d = 8'h4f, r;
  int n_mismatch = 0, n_compared = 0, cyc = 0, tout;
  integer seed = 32'h9f29628f, n, nt;
  fcr_flash_ctrl #(.STEP_CYC(STEP)) dut_u (.*);
  fcr_host host_u (.*);
  initial
    forever #2.5 clk = ~clk;
  task w(input [7:0] a, input [7:0] v);
    host_u.wr(a, v);
    t = (a == 8'ha0) ? v : (a == 8'hb0) ? {t[7:3], v[2:0]} : t;
    f = (a == 8'hb0) ? v : (a == 8'ha0) ? {f[7:3], v[2:0]} : f;
    d = (a == 8'hc0) ? v & 8'h7f : d;
  endtask
  task chk;
    host_u.rd(8'ha0, r); `CHK(r, t)
    host_u.rd(8'hb0, r); `CHK(r, f)
    host_u.rd(8'hc0, r); `CHK(r, d)
    host_u.rd(8'h10, r); `CHK(r, 8'h00)
    `CHK({mode_shutdown, mode_indicator, mode_torch, mode_flash, voltage_output_select}, {f[2:0] == 3'h0,
      f[1:0] == 2'h1, f[1:0] == 2'h2, f[1:0] == 2'h3, f[2]})
    `CHK(flash_current_code, f[6:3])
    `CHK(peak_limit_code, d[6:5])
  endtask
  task smp;
    @(negedge clk);
    n += flash_on;
    nt += flash_timed_out;
  endtask
  // Level mode with a short hold must stop early and keep the mode; a timeout clears it.
  task fl(input [7:0] fv, input [7:0] dv, input int hold);
    w(8'hc0, dv);
    w(8'hb0, fv);
    tout = (dv[4:0] + 1) * STEP;
    n = 0;
    nt = 0;
    @(negedge clk) trigger_in = 1'b1;
    repeat (hold) smp;
    trigger_in = 1'b0;
    repeat (140) smp;
    if (fv[7] || hold > tout)
      `CHK(n, tout)
    else
      `CHK(n, hold)
    `CHK(nt, (fv[7] || hold > tout) ? 1 : 0)
    if (fv[7] || hold > tout)
      {t[1:0], f[1:0]} = 4'h0;
    chk;
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
    forever @(posedge clk) if (++cyc == 5000) begin n_mismatch++; summarize; end
  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    chk;
    repeat (40)
    begin
      w(8'ha0 + 8'h10 * ($unsigned($random(seed)) % 3), $random(seed));
      chk;
    end
    fl(8'h8b, 8'h41, 2);
    fl(8'h0f, 8'h40, 20);
    fl(8'h0b, 8'h43, 3);
    fl(8'h8f, 8'h5f, 2);
    summarize;
  end
endmodule // test_fcr_flash_ctrl
bind fcr_flash_ctrl fcr_chk chk_u (.*);
